// [shared/asram_pkg.sv]
/*
  constants and types for the asynchronous sram controller.
  assumes a 200 mhz mclk and the slowest speed grade figures.
*/
package asram_pkg;
  localparam int ASRAM_ADDR_W = 19;
  localparam int ASRAM_DATA_W = 8;
  localparam int ASRAM_CLK_PS = 5000;
  // ---------------------------------------------
  // timing figures in ns (slowest grade)
  // ---------------------------------------------
  localparam int WRITE_CYCLE_MIN_NS = 12;
  localparam int WRITE_PULSE_NS = 8;
  localparam int DATA_TO_WRITE_END_NS = 6;
  localparam int READ_ACCESS_NS = 12;
  localparam int OUTPUT_FLOAT_NS = 6;
  // least times round up
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_MIN_NS * 1000 + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS + 1;
  localparam int FLOAT_CYC = (OUTPUT_FLOAT_NS * 1000 + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
  localparam int RECOVER_CYC = WRITE_CYCLE_CYC - WRITE_PULSE_CYC;
  localparam int ASRAM_CNT_W = 4;
  localparam logic [ASRAM_CNT_W-1:0] ASRAM_CNT_ONE = 4'h1;
  localparam logic [ASRAM_ADDR_W-1:0] ASRAM_ADDR_RST = 19'h0_0000;
  localparam logic [ASRAM_DATA_W-1:0] ASRAM_DATA_RST = 8'h00;
  typedef enum logic [4:0] {
    ASRAM_IDLE = 5'b00001,
    ASRAM_WSET = 5'b00010,
    ASRAM_WPUL = 5'b00100,
    ASRAM_WREC = 5'b01000,
    ASRAM_READ = 5'b10000
  } asram_state_t;
endpackage : asram_pkg

// [shared/asram_tmr_if.sv]
/*
  carrier between the sequencer and its delay counter.
  assumes both ends share mclk.
*/
`timescale 1ns/1ps
interface asram_tmr_if;
  import asram_pkg::*;
  logic load;
  logic [ASRAM_CNT_W-1:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : asram_tmr_if

// [src/asram_tmr.sv]
/*
  down counter giving the length of the read, write pulse and write recovery phases.
  assumes each load carries a nonzero count; a write start holds load for two cycles in a row.
*/
`timescale 1ns/1ps
module asram_tmr
  import asram_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  asram_tmr_if.tmr t
);
  logic [ASRAM_CNT_W-1:0] cnt_q;
  logic [ASRAM_CNT_W-1:0] cnt_d;
  assign cnt_d = t.load ? t.count : (cnt_q != '0 ? cnt_q - ASRAM_CNT_ONE : cnt_q);
  // done reads the count alone: the sequencer builds load from done, so gating here would loop
  assign t.done = (cnt_q == ASRAM_CNT_ONE);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : asram_tmr

// [src/asram_ctrl.sv]
/*
  host controller driving a 512k x 8 asynchronous static ram.
  assumes the ram pins are registered outputs of this block and that
  read data settle within the access count before being sampled.
*/
// Operation
// - address stable before chip select falls
// - write strobe high through every read
// - address changes only with strobes high
// - never drive data while ram drives
// - output drive high during writes
// - address held through whole write pulse
// - data stable before write end
// - controls are active low
`timescale 1ns/1ps
module asram_ctrl
  import asram_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ASRAM_ADDR_W-1:0] req_addr,
  input wire logic [ASRAM_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic [ASRAM_DATA_W-1:0] rsp_rdata,
  output logic rsp_valid,
  output logic [ASRAM_ADDR_W-1:0] address_lines,
  output logic chip_sel_n,
  output logic write_n,
  output logic out_drive_n,
  output logic [ASRAM_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [ASRAM_DATA_W-1:0] data_lines_in
);
  // ---------------------------------------------
  // state and pin registers
  // ---------------------------------------------
  asram_state_t state_q, state_d;
  logic [ASRAM_ADDR_W-1:0] addr_q, addr_d;
  logic [ASRAM_DATA_W-1:0] wdata_q, wdata_d;
  logic [ASRAM_DATA_W-1:0] rdata_q, rdata_d;
  logic cs_n_q, cs_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, doe_q, doe_d, rv_q, rv_d;
  asram_tmr_if tif ();
  asram_tmr u_tmr (
    .mclk(mclk),
    .reset(reset),
    .t(tif.tmr)
  );
  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  wire idle = (state_q == ASRAM_IDLE);
  // no float wait after a read: a request is taken on any idle cycle
  wire take = idle && req_valid;
  wire take_wr = take && req_write;
  wire take_rd = take && !req_write;
  wire in_wset = (state_q == ASRAM_WSET);
  wire in_wpul = (state_q == ASRAM_WPUL);
  wire in_wrec = (state_q == ASRAM_WREC);
  wire in_read = (state_q == ASRAM_READ);
  wire tdone = tif.done;
  assign req_ready = idle;
  assign tif.load = take || (in_wset) || (in_wpul && tdone);
  assign tif.count = take_rd ? 4'(READ_ACCESS_CYC) : (in_wset ? 4'(WRITE_PULSE_CYC) : 4'(RECOVER_CYC));
  always_comb begin
    state_d = state_q;
    addr_d = take ? req_addr : addr_q;
    wdata_d = take_wr ? req_wdata : wdata_q;
    rdata_d = rdata_q;
    cs_n_d = cs_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    doe_d = doe_q;
    rv_d = 1'b0;
    unique case (state_q)
      ASRAM_IDLE: begin
        if (take_wr) begin
          state_d = ASRAM_WSET;
          oe_n_d = 1'b1;
        end else if (take_rd) begin
          state_d = ASRAM_READ;
          we_n_d = 1'b1;
        end
      end
      ASRAM_WSET: begin
        // address already stable a cycle; data drives as the pulse opens
        state_d = ASRAM_WPUL;
        cs_n_d = 1'b0;
        we_n_d = 1'b0;
        doe_d = 1'b1;
      end
      ASRAM_WPUL: begin
        if (tdone) begin
          state_d = ASRAM_WREC;
          cs_n_d = 1'b1;
          we_n_d = 1'b1;
        end
      end
      ASRAM_WREC: begin
        // data held one cycle past strobe rise, zero hold suffices
        doe_d = 1'b0;
        if (tdone) begin
          state_d = ASRAM_IDLE;
        end
      end
      ASRAM_READ: begin
        cs_n_d = 1'b0;
        oe_n_d = 1'b0;
        if (tdone) begin
          state_d = ASRAM_IDLE;
          rdata_d = data_lines_in;
          rv_d = 1'b1;
          cs_n_d = 1'b1;
          oe_n_d = 1'b1;
        end
      end
      default: begin
        state_d = ASRAM_IDLE;
      end
    endcase
  end
  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= ASRAM_IDLE;
      addr_q <= ASRAM_ADDR_RST;
      wdata_q <= ASRAM_DATA_RST;
      rdata_q <= ASRAM_DATA_RST;
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_q <= 1'b0;
      rv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      cs_n_q <= cs_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      doe_q <= doe_d;
      rv_q <= rv_d;
    end
  end
  assign address_lines = addr_q;
  assign chip_sel_n = cs_n_q;
  assign write_n = we_n_q;
  assign out_drive_n = oe_n_q;
  assign data_lines_out = wdata_q;
  assign data_lines_oe = doe_q;
  assign rsp_rdata = rdata_q;
  assign rsp_valid = rv_q;
endmodule : asram_ctrl

// [test/asram_sram_model.sv]
/* behavioural ram on the far side of asram_ctrl.
   zero delay, so float and turn-on times hold trivially. */
`timescale 1ns/1ps
module asram_sram_model
  import asram_pkg::*;
(
  input wire logic [ASRAM_ADDR_W-1:0] address_lines,
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic out_drive_n,
  input wire logic [ASRAM_DATA_W-1:0] data_wire,
  output logic [ASRAM_DATA_W-1:0] mem_dout,
  output logic mem_drive
);
  logic [ASRAM_DATA_W-1:0] mem [0:(1<<ASRAM_ADDR_W)-1];
  logic [ASRAM_DATA_W-1:0] last_q = 8'h00;
  logic wr_q = 1'b0;
  always @(chip_sel_n or write_n) begin
    if (wr_q && (chip_sel_n || write_n)) mem[address_lines] = data_wire;
    wr_q = !chip_sel_n && !write_n;
  end
  assign mem_drive = !chip_sel_n && write_n && !out_drive_n;
  always @* if (mem_drive) last_q = mem[address_lines];
  // a released line shows the inverse, never a stale copy
  assign mem_dout = mem_drive ? last_q : ~last_q;
endmodule : asram_sram_model

// [test/asram_ctrl_chk.sv]
/* pin checker for asram_ctrl.
   bound to the controller, one clock domain. */
`timescale 1ns/1ps
module asram_chk
  import asram_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [ASRAM_ADDR_W-1:0] address_lines,
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic out_drive_n,
  input wire logic [ASRAM_DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic take;
  assign take = req_valid && req_ready;
  chk_rd_answer: assert property (take && !req_write |-> ##5 rsp_valid) else $error("read late");
  chk_wr_start: assert property (take && req_write |-> ##2 !chip_sel_n && !write_n) else $error("no write");
  chk_wr_pulse: assert property ($fell(write_n) |-> !write_n [*2] ##1 write_n) else $error("pulse");
  chk_wr_space: assert property ($rose(write_n) |-> write_n [*3]) else $error("spacing");
  chk_addr_hold: assert property (!chip_sel_n && !write_n |-> $stable(address_lines)) else $error("addr");
  chk_cs_addr: assert property ($fell(chip_sel_n) |-> $stable(address_lines)) else $error("cs addr");
  chk_rd_strobe: assert property (!chip_sel_n && !out_drive_n |-> write_n) else $error("we in read");
  chk_no_fight: assert property (data_lines_oe |-> out_drive_n) else $error("contention");
  chk_oe_write: assert property (!write_n |-> out_drive_n && data_lines_oe) else $error("oe");
  chk_data_set: assert property ($rose(write_n) |-> $past(data_lines_out, 1) == $past(data_lines_out, 2)) else $error("data");
  cover property (take && req_write);
  cover property (take && !req_write);
  cover property ($rose(write_n) ##[1:4] take);
endmodule : asram_chk
bind asram_ctrl asram_chk chk_i (.mclk, .reset, .req_valid, .req_write, .req_ready, .rsp_valid,
  .address_lines, .chip_sel_n, .write_n, .out_drive_n, .data_lines_out, .data_lines_oe);

// [test/async_sram_write_cycle_tb.sv]
/* testbench: controller against the ram model.
   stimulus by nonblocking drive on the rising edge. */
`timescale 1ns/1ps
module async_sram_write_cycle_tb;
  import asram_pkg::*;
  logic mclk = 0, reset = 1, req_valid = 0, req_write = 0, req_ready, rsp_valid;
  logic chip_sel_n, write_n, out_drive_n, data_lines_oe, mem_drive;
  logic [ASRAM_ADDR_W-1:0] req_addr = ASRAM_ADDR_RST, address_lines;
  logic [ASRAM_DATA_W-1:0] req_wdata = ASRAM_DATA_RST, rsp_rdata, data_lines_out, mem_dout, data_wire;
  int fail_count = 0, n_checks = 0;
  assign data_wire = data_lines_oe ? data_lines_out : mem_dout;
  asram_ctrl dut (.mclk, .reset, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rsp_rdata,
    .rsp_valid, .address_lines, .chip_sel_n, .write_n, .out_drive_n, .data_lines_out, .data_lines_oe,
    .data_lines_in(data_wire));
  asram_sram_model ram (.address_lines, .chip_sel_n, .write_n, .out_drive_n, .data_wire, .mem_dout, .mem_drive);
  initial forever #2.5 mclk = ~mclk;
  task chk(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // held until the edge that sees ready, so a busy controller just stalls us
  task issue(input logic w, input logic [18:0] a, input logic [7:0] d);
    int i;
    i = 0;
    req_valid <= 1'b1; req_write <= w; req_addr <= a; req_wdata <= d;
    do begin
      @(posedge mclk);
      i++;
      if (i > 20) begin
        fail_count++;
        give_verdict;
      end
    end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // one edge with valid low, so a following call never re-raises it in this time step
    @(posedge mclk);
  endtask : issue
  task rd(input logic [18:0] a, input logic [7:0] e);
    issue(1'b0, a, 8'h00);
    repeat (4) @(posedge mclk);
    chk(rsp_valid, 1'b1);
    chk(rsp_rdata, e);
  endtask : rd
  task t_store;
    issue(1'b1, 19'h0_0000, 8'ha5);
    issue(1'b1, 19'h7_ffff, 8'h5a);
    rd(19'h0_0000, 8'ha5);
    rd(19'h7_ffff, 8'h5a);
    $display("store done");
  endtask : t_store
  task t_turn;
    rd(19'h0_0000, 8'ha5);
    issue(1'b1, 19'h0_0000, 8'h3c);
    issue(1'b1, 19'h5_5555, 8'hc3);
    rd(19'h0_0000, 8'h3c);
    rd(19'h5_5555, 8'hc3);
    chk(chip_sel_n & out_drive_n, 1'b1);
    $display("turn done");
  endtask : t_turn
  // a reset in mid-read must drop every strobe and forget the pending answer
  task t_reset;
    issue(1'b0, 19'h0_0000, 8'h00);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    chk(chip_sel_n & write_n & out_drive_n, 1'b1);
    chk(data_lines_oe, 1'b0);
    chk(rsp_valid, 1'b0);
    chk(req_ready, 1'b1);
    reset <= 1'b0;
    @(posedge mclk);
    rd(19'h5_5555, 8'hc3);
    $display("reset done");
  endtask : t_reset
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_store;
    t_turn;
    t_reset;
    give_verdict;
  end
endmodule : async_sram_write_cycle_tb
